// ### bench/smcs_mem_model.sv
// Far-side memories accept writes only when typed SRAM or variable latency.
module smcs_mem_model
    import smcs_pkg::*;
(
    // Decoded memory types
    input  wire smcs_mem_t [3:0] mem_type,
    // Writable flag per select
    output logic      [3:0]      write_ok
);
    timeunit 1ns;
    timeprecision 1ps;
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            write_ok[i] = mem_type[i] inside
                {SMCS_MEM_SRAM, SMCS_MEM_VAR_LAT};
        end
    end
endmodule

// ### bench/static_mem_chip_select_config_bench.sv
`include "smcs_defines.svh"
module static_mem_chip_select_config_bench;
    import smcs_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic              clk, reset_n, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]        paddr;
    logic [31:0]       pwdata, prdata, rd;
    logic [3:0]        pstrb, wr_ok;
    logic [3:0][2:0]   sat;
    logic [3:0][3:0]   sdt;
    smcs_mem_t [3:0]   mts;
    smcs_adr_t [4:0]   ik;
    logic [4:0][3:0]   ucf;
    logic [4:0]        sup;
    int                error_cnt = 0;
    int                checked = 0;

    smcs_regs u_dut (.clk(clk), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .strobe_assert_time(sat), .strobe_data_time(sdt),
        .memory_type_sel(mts), .interface_kind(ik),
        .upper_cycle_first_bit(ucf), .split_supported(sup));
    smcs_mem_model u_mem (.mem_type(mts), .write_ok(wr_ok));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report;
        $display("Checks %0d, mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The wait is bounded so that a slave that never answers ends the run.
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= s;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            error_cnt++;
            final_report();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rdchk(input string nm, input logic [7:0] a,
                         input logic [31:0] exp);
        apb(1'b0, a, 32'h0000_0000, 4'hF);
        chk(nm, rd, exp);
        chk("read error flag", {31'h0, err}, 32'h0000_0000);
    endtask

    initial begin
        {reset_n, psel, penable, pwrite, paddr, pwdata, pstrb} = '0;
        repeat (8) @(posedge clk);
        reset_n <= 1'b1;
        rdchk("pair01 reset", `SMCS_OFF_PAIR01, `SMCS_PAIR_RESET);
        rdchk("pair23 reset", `SMCS_OFF_PAIR23, `SMCS_PAIR_RESET);
        for (int i = 0; i < 4; i++) begin
            rdchk("addr reset", 8'h80 + 8'(4 * i), `SMCS_ADDR_RESET);
        end
        chk("type0 reset", {30'h0, mts[0]}, {30'h0, SMCS_MEM_FLASH});
        apb(1'b0, `SMCS_OFF_ADDRP, 32'h0000_0000, 4'hF);
        chk("card slot absent", {31'h0, err}, 32'h0000_0001);
        $display("Test reset values done");
        apb(1'b1, `SMCS_OFF_PAIR01, 32'hFFFF_FFFF, 4'hF);
        rdchk("pair01 mask", `SMCS_OFF_PAIR01, 32'h0FFF_0FFF);
        apb(1'b1, `SMCS_OFF_PAIR23, 32'h06A4_0351, 4'hF);
        rdchk("pair23 back", `SMCS_OFF_PAIR23, 32'h06A4_0351);
        chk("type2", {30'h0, mts[2]}, {30'h0, SMCS_MEM_SRAM});
        chk("type3", {30'h0, mts[3]}, {30'h0, SMCS_MEM_VAR_LAT});
        chk("assert2", {29'h0, sat[2]}, 32'h0000_0003);
        chk("data3", {28'h0, sdt[3]}, 32'h0000_000A);
        chk("writable", {28'h0, wr_ok}, 32'h0000_000C);
        $display("Test pair timing done");
        // Reserved scheme 010 and split code A must decode as unsupported.
        apb(1'b1, `SMCS_OFF_ADDR2, 32'h0000_4900, 4'hF);
        apb(1'b1, `SMCS_OFF_ADDR3, 32'h0000_C800, 4'hF);
        apb(1'b1, `SMCS_OFF_ADDR1, 32'h0000_8A00, 4'hF);
        rdchk("addr3 back", `SMCS_OFF_ADDR3, 32'h0000_C800);
        chk("kind2", {30'h0, ik[2]}, {30'h0, SMCS_ADR_FULL_LATCH});
        chk("kind3", {30'h0, ik[3]}, {30'h0, SMCS_ADR_LOW_ORDER});
        chk("kind1", {30'h0, ik[1]}, {30'h0, SMCS_ADR_BAD});
        chk("split2", {28'h0, ucf[2]}, 32'h0000_0009);
        chk("split3", {28'h0, ucf[3]}, 32'h0000_0008);
        chk("split ok", {27'h0, sup}, 32'h0000_000C);
        $display("Test address setup done");
        apb(1'b1, `SMCS_OFF_PAIR23, 32'h0000_0000, 4'h3);
        chk("partial write", {31'h0, err}, 32'h0000_0001);
        rdchk("pair23 kept", `SMCS_OFF_PAIR23, 32'h06A4_0351);
        apb(1'b0, 8'h40, 32'h0000_0000, 4'hF);
        chk("unmapped", {31'h0, err}, 32'h0000_0001);
        $display("Test refusals done");
        final_report();
    end

    initial begin
        repeat (5000) @(posedge clk);
        error_cnt++;
        final_report();
    end
endmodule

// ### core/smcs_defines.svh
`ifndef SMCS_DEFINES_SVH
`define SMCS_DEFINES_SVH

// Byte addresses of the register words.
`define SMCS_OFF_PAIR01   8'h08
`define SMCS_OFF_PAIR23   8'h0C
`define SMCS_OFF_ADDR0    8'h80
`define SMCS_OFF_ADDR1    8'h84
`define SMCS_OFF_ADDR2    8'h88
`define SMCS_OFF_ADDR3    8'h8C
`define SMCS_OFF_ADDRP    8'h90

// Pair timing register: writable bits and reset value.
`define SMCS_PAIR_MASK    32'h0FFF_0FFF
`define SMCS_PAIR_RESET   32'h0FF0_0FF0
// Address setup register: writable bits and reset value.
`define SMCS_ADDR_MASK    32'h003F_CF3F
`define SMCS_ADDR_RESET   32'h0002_0000

// Field positions within one chip-select group of a pair register, and the bit where the upper group starts.
`define SMCS_TYPE_LSB     0
`define SMCS_DATA_LSB     4
`define SMCS_ASSERT_LSB   8
`define SMCS_GROUP_HI     16
// Field positions within an address setup register.
`define SMCS_SCHEME_LSB   14
`define SMCS_SPLIT_LSB    8

// Field codes.
`define SMCS_TYPE_FLASH   3'h0
`define SMCS_TYPE_SRAM    3'h1
`define SMCS_TYPE_VAR_LAT 3'h4
`define SMCS_SCHEME_FULL  3'h1
`define SMCS_SCHEME_LOW   3'h3
`define SMCS_SPLIT_B16    4'h8
`define SMCS_SPLIT_B17    4'h9

`endif

// ### core/smcs_pkg.sv
package smcs_pkg;
    typedef enum logic [1:0] {
        SMCS_MEM_FLASH,
        SMCS_MEM_SRAM,
        SMCS_MEM_VAR_LAT,
        SMCS_MEM_BAD
    } smcs_mem_t;

    typedef enum logic [1:0] {
        SMCS_ADR_FULL_LATCH,
        SMCS_ADR_LOW_ORDER,
        SMCS_ADR_BAD
    } smcs_adr_t;
endpackage

// ### core/smcs_regs.sv
// Decided for this implementation: the placing of the registers and the APB interface to the registers.
`include "smcs_defines.svh"

module smcs_regs
    import smcs_pkg::*;
#(
    parameter bit HAS_CS01 = 1'b1
) (
    // Clock and reset
    input  wire logic        clk,
    input  wire logic        reset_n,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Decoded per-select configuration, 0..3; address-setup outputs add the card slot as index 4
    output logic [3:0][2:0]  strobe_assert_time,
    output logic [3:0][3:0]  strobe_data_time,
    output smcs_mem_t [3:0]  memory_type_sel,
    output smcs_adr_t [4:0]  interface_kind,
    output logic [4:0][3:0]  upper_cycle_first_bit,
    output logic [4:0]       split_supported
);

    logic [31:0]      pair_reg [2];
    logic [31:0]      addr_reg [5];
    logic             sel_ok;
    logic [2:0]       widx;
    logic             is_pair;
    logic             present;

    function automatic smcs_mem_t dec_type(input logic [2:0] code);
        unique case (code)
            `SMCS_TYPE_FLASH: dec_type = SMCS_MEM_FLASH;
            `SMCS_TYPE_SRAM:  dec_type = SMCS_MEM_SRAM;
            `SMCS_TYPE_VAR_LAT: dec_type = SMCS_MEM_VAR_LAT;
            default:          dec_type = SMCS_MEM_BAD;
        endcase
    endfunction

    function automatic smcs_adr_t dec_scheme(input logic [2:0] code);
        unique case (code)
            `SMCS_SCHEME_FULL: dec_scheme = SMCS_ADR_FULL_LATCH;
            `SMCS_SCHEME_LOW:  dec_scheme = SMCS_ADR_LOW_ORDER;
            default:           dec_scheme = SMCS_ADR_BAD;
        endcase
    endfunction

    // Address decode: slot index and whether the word exists on this variant.
    always_comb begin
        widx    = 3'h0;
        is_pair = 1'b0;
        present = 1'b1;
        unique case (paddr)
            `SMCS_OFF_PAIR01: begin
                is_pair = 1'b1;
                present = HAS_CS01;
            end
            `SMCS_OFF_PAIR23: begin
                is_pair = 1'b1;
                widx    = 3'h1;
            end
            `SMCS_OFF_ADDR0: present = HAS_CS01;
            `SMCS_OFF_ADDR1: begin
                widx    = 3'h1;
                present = HAS_CS01;
            end
            `SMCS_OFF_ADDR2: widx = 3'h2;
            `SMCS_OFF_ADDR3: widx = 3'h3;
            `SMCS_OFF_ADDRP: begin
                widx    = 3'h4;
                present = !HAS_CS01;
            end
            default: present = 1'b0;
        endcase
    end

    // Partial-word writes are refused so a register never holds a torn value.
    assign sel_ok = present && (!pwrite || pstrb == 4'hF);

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            pair_reg[0] <= `SMCS_PAIR_RESET;
            pair_reg[1] <= `SMCS_PAIR_RESET;
        end else if (psel && penable && pwrite && sel_ok && is_pair) begin
            pair_reg[widx[0]] <= pwdata & `SMCS_PAIR_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            for (int i = 0; i < 5; i++) addr_reg[i] <= `SMCS_ADDR_RESET;
        end else if (psel && penable && pwrite && sel_ok && !is_pair) begin
            addr_reg[widx] <= pwdata & `SMCS_ADDR_MASK;
        end
    end

    // Zero-wait APB: data registered during setup, answer in the access cycle.
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata  <= 32'h0000_0000;
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= psel && !penable;
            pslverr <= psel && !penable && !sel_ok;
            if (psel && !penable && !pwrite && sel_ok)
                prdata <= is_pair ? pair_reg[widx[0]] : addr_reg[widx];
            else
                prdata <= 32'h0000_0000;
        end
    end

    // Field groups are identical; group k of register p serves select 2p+k.
    // Timing fields pass through unchanged because the sequencer counts them
    // on divided memory-bus clock edges; synchronous mode uses them too.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_cs
            localparam int BASE = (g % 2) * `SMCS_GROUP_HI;
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    strobe_assert_time[g] <= 3'h7;
                    strobe_data_time[g]   <= 4'hF;
                    memory_type_sel[g]    <= SMCS_MEM_FLASH;
                end else begin
                    strobe_assert_time[g] <=
                        pair_reg[g/2][BASE+`SMCS_ASSERT_LSB +: 3];
                    strobe_data_time[g]   <=
                        pair_reg[g/2][BASE+`SMCS_DATA_LSB +: 4];
                    memory_type_sel[g]    <= dec_type(
                        pair_reg[g/2][BASE+`SMCS_TYPE_LSB +: 3]);
                end
            end
        end
        for (g = 0; g < 5; g++) begin : g_adr
            always_ff @(posedge clk) begin
                if (!reset_n) begin
                    interface_kind[g]        <= SMCS_ADR_BAD;
                    upper_cycle_first_bit[g] <= 4'h0;
                    split_supported[g]       <= 1'b0;
                end else begin
                    interface_kind[g] <= dec_scheme(
                        addr_reg[g][`SMCS_SCHEME_LSB +: 3]);
                    upper_cycle_first_bit[g] <=
                        addr_reg[g][`SMCS_SPLIT_LSB +: 4];
                    split_supported[g] <=
                        addr_reg[g][`SMCS_SPLIT_LSB +: 4] == `SMCS_SPLIT_B16 ||
                        addr_reg[g][`SMCS_SPLIT_LSB +: 4] == `SMCS_SPLIT_B17;
                end
            end
        end
    endgenerate

    wire apb_wr = psel && penable && pwrite && sel_ok;

    pready_setup_a: assert property (@(posedge clk) disable iff (!reset_n)
        psel && !penable |=> pready) else $error("no ready after setup");
    pready_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        !psel |=> !pready) else $error("ready without select");
    readback_new_a: assert property (@(posedge clk) disable iff (!reset_n)
        apb_wr && is_pair |=> pair_reg[$past(widx[0])] ==
            ($past(pwdata) & `SMCS_PAIR_MASK))
        else $error("pair write not stored");
    addr_store_a: assert property (@(posedge clk) disable iff (!reset_n)
        apb_wr && !is_pair |=> addr_reg[$past(widx)] ==
            ($past(pwdata) & `SMCS_ADDR_MASK))
        else $error("address write not stored");
    part_refuse_a: assert property (@(posedge clk) disable iff (!reset_n)
        psel && !penable && pwrite && pstrb != 4'hF |=> pslverr)
        else $error("partial write accepted");
    type_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        pair_reg[1][`SMCS_TYPE_LSB +: 3] == `SMCS_TYPE_VAR_LAT
        |=> memory_type_sel[2] == SMCS_MEM_VAR_LAT)
        else $error("type decode wrong");
    group_hi_a: assert property (@(posedge clk) disable iff (!reset_n)
        1'b1 |=> strobe_data_time[3] ==
            $past(pair_reg[1][`SMCS_GROUP_HI+`SMCS_DATA_LSB +: 4]))
        else $error("upper group wrong");
    scheme_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        addr_reg[2][`SMCS_SCHEME_LSB +: 3] == `SMCS_SCHEME_LOW
        |=> interface_kind[2] == SMCS_ADR_LOW_ORDER)
        else $error("scheme decode wrong");
    split_dec_a: assert property (@(posedge clk) disable iff (!reset_n)
        addr_reg[3][`SMCS_SPLIT_LSB +: 4] == `SMCS_SPLIT_B17
        |=> split_supported[3]) else $error("split decode wrong");

    // Bus answer shape: error only with ready, data zero outside reads.
    pslverr_ready_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        pslverr |-> pready)
        else $error("error flag without ready");

    prdata_idle_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !pready |-> prdata == 32'h0000_0000)
        else $error("read data outside access");

    write_rdata_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && !penable && pwrite |=> prdata == 32'h0000_0000)
        else $error("read data on a write");

    // A refused write must leave both pair registers and address registers 2 and 3 untouched.
    refuse_pair_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && penable && pwrite && !sel_ok |=>
            $stable(pair_reg[0]) && $stable(pair_reg[1]))
        else $error("refused write changed pair");

    refuse_addr_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && penable && pwrite && !sel_ok |=>
            $stable(addr_reg[2]) && $stable(addr_reg[3]))
        else $error("refused write changed address");

    pair_reserved_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> (pair_reg[1] & ~`SMCS_PAIR_MASK) == 32'h0000_0000)
        else $error("pair reserved bit set");

    addr_reserved_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> (addr_reg[2] & ~`SMCS_ADDR_MASK) == 32'h0000_0000)
        else $error("address reserved bit set");

    // Variant presence: a missing word answers with an error.
    absent_card_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        HAS_CS01 && psel && !penable && paddr == `SMCS_OFF_ADDRP
        |=> pslverr) else $error("card slot word answered");

    absent_pair_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        !HAS_CS01 && psel && !penable && paddr == `SMCS_OFF_PAIR01
        |=> pslverr) else $error("first pair word answered");

    unmapped_err_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && !penable && !present |=> pslverr)
        else $error("unmapped word without error");

    mapped_read_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && !penable && present && !pwrite |=> !pslverr)
        else $error("mapped read flagged");

    read_pair_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && !penable && !pwrite && sel_ok && is_pair
        |=> prdata == $past(pair_reg[widx[0]]))
        else $error("pair read data wrong");

    read_addr_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        psel && !penable && !pwrite && sel_ok && !is_pair
        |=> prdata == $past(addr_reg[widx]))
        else $error("address read data wrong");

    // Decoded outputs follow their register fields one clock later.
    assert_time_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> strobe_assert_time[2] ==
            $past(pair_reg[1][`SMCS_ASSERT_LSB +: 3]))
        else $error("assert time wrong");

    data_time_lo_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> strobe_data_time[0] ==
            $past(pair_reg[0][`SMCS_DATA_LSB +: 4]))
        else $error("data time wrong");

    type_sram_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        pair_reg[0][`SMCS_GROUP_HI +: 3] == `SMCS_TYPE_SRAM
        |=> memory_type_sel[1] == SMCS_MEM_SRAM)
        else $error("sram type decode wrong");

    type_flash_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        pair_reg[0][`SMCS_TYPE_LSB +: 3] == `SMCS_TYPE_FLASH
        |=> memory_type_sel[0] == SMCS_MEM_FLASH)
        else $error("flash type decode wrong");

    scheme_full_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        addr_reg[4][`SMCS_SCHEME_LSB +: 3] == `SMCS_SCHEME_FULL
        |=> interface_kind[4] == SMCS_ADR_FULL_LATCH)
        else $error("full latch decode wrong");

    scheme_bad_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        addr_reg[1][`SMCS_SCHEME_LSB +: 3] != `SMCS_SCHEME_FULL &&
        addr_reg[1][`SMCS_SCHEME_LSB +: 3] != `SMCS_SCHEME_LOW
        |=> interface_kind[1] == SMCS_ADR_BAD)
        else $error("reserved scheme accepted");

    split_copy_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        1'b1 |=> upper_cycle_first_bit[0] ==
            $past(addr_reg[0][`SMCS_SPLIT_LSB +: 4]))
        else $error("split field wrong");

    split_bad_a: assert property (
        @(posedge clk) disable iff (!reset_n)
        addr_reg[1][`SMCS_SPLIT_LSB +: 4] != `SMCS_SPLIT_B16 &&
        addr_reg[1][`SMCS_SPLIT_LSB +: 4] != `SMCS_SPLIT_B17
        |=> !split_supported[1])
        else $error("reserved split accepted");

endmodule
